// ==== pkg/usrre_consts.svh ====
/*
 Opcodes, cycle counts and flag bit positions for the stack, return and rotate executor.
 Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef USRRE_CONSTS_SVH
`define USRRE_CONSTS_SVH
`define USRRE_OP_PUSH_INC 8'h83
`define USRRE_OP_CARRY_CLR 8'hCF
`define USRRE_OP_RETURN 8'hAF
`define USRRE_OP_ROTL_R 8'h90
`define USRRE_OP_ROTL_IR 8'h91
`define USRRE_CYC_PUSH 4'h8
`define USRRE_CYC_CARRY 4'h4
`define USRRE_CYC_RET_INT 4'h8
`define USRRE_CYC_RET_EXT 4'hA
`define USRRE_CYC_ROTL 4'h4
`define USRRE_SP_STEP 16'h0002
`define USRRE_FLAG_C 7
`define USRRE_FLAG_Z 6
`define USRRE_FLAG_S 5
`define USRRE_FLAG_V 4
`define USRRE_FLAGS_RESET 8'h00
`define USRRE_PC_RESET 16'h0000
`define USRRE_SP_RESET 16'h0000
`endif

// ==== pkg/usrre_pkg.sv ====
/*
 Types for the stack, return and rotate executor.
 Assumes the constants header is on the include path.
*/
package usrre_pkg;
`include "usrre_consts.svh"
   typedef enum logic [1:0] {USRRE_OPK_PUSH, USRRE_OPK_CARRY, USRRE_OPK_RET,
      USRRE_OPK_ROTL} usrre_opkind_type;
   typedef enum {USRRE_IDLE, USRRE_PTR, USRRE_IND, USRRE_DATA, USRRE_STK_HI, USRRE_STK_LO,
      USRRE_WAIT} usrre_state_type;
endpackage

// ==== hdl/usrre_decode.sv ====
/*
 Opcode decoder: legality, kind, indirect mode and cycle budget of one opcode.
 Assumes a stable opcode from the fetch stage; purely combinational, same clock.
*/
`timescale 1ns/1ps
`include "usrre_consts.svh"
module usrre_decode
   import usrre_pkg::*;
(
   input wire logic [7:0] opcode,
   input wire logic extStack,
   output logic legal,
   output usrre_opkind_type kind,
   output logic indirect,
   output logic [3:0] cycles
);
   always_comb begin
      legal = 1'b1;
      kind = USRRE_OPK_CARRY;
      indirect = 1'b0;
      cycles = `USRRE_CYC_CARRY;
      unique case (opcode)
         `USRRE_OP_PUSH_INC: begin
            kind = USRRE_OPK_PUSH;
            indirect = 1'b1;
            cycles = `USRRE_CYC_PUSH;
         end
         `USRRE_OP_CARRY_CLR: begin
            kind = USRRE_OPK_CARRY;
         end
         `USRRE_OP_RETURN: begin
            kind = USRRE_OPK_RET;
            cycles = extStack ? `USRRE_CYC_RET_EXT : `USRRE_CYC_RET_INT;
         end
         `USRRE_OP_ROTL_R, `USRRE_OP_ROTL_IR: begin
            kind = USRRE_OPK_ROTL;
            indirect = opcode[0];
            cycles = `USRRE_CYC_ROTL;
         end
         default: legal = 1'b0;
      endcase
   end
endmodule // usrre_decode

// ==== hdl/usrre_rotl.sv ====
/*
 Rotate-left datapath with carry, zero, sign and overflow results.
 Assumes an 8-bit operand; combinational.
*/
`timescale 1ns/1ps
`include "usrre_consts.svh"
module usrre_rotl
   import usrre_pkg::*;
(
   input wire logic [7:0] operand,
   input wire logic [7:0] flagsIn,
   output logic [7:0] result,
   output logic [7:0] flagsOut
);
   always_comb begin
      result = {operand[6:0], operand[7]};
      flagsOut = flagsIn;
      flagsOut[`USRRE_FLAG_C] = operand[7];
      flagsOut[`USRRE_FLAG_Z] = (result == 8'h00);
      flagsOut[`USRRE_FLAG_S] = result[7];
      flagsOut[`USRRE_FLAG_V] = result[7] ^ operand[7];
   end
endmodule // usrre_rotl

// ==== hdl/usrre_exec.sv ====
/*
 Executor for the incrementing user-stack push, carry clear, subroutine return
 and rotate left. Register file and stack memory are outside: reads are
 combinational (data valid in the cycle the address is shown), writes take effect
 on the clock edge where the write strobe is high. Single clock, synchronous reset.
*/
// Behaviour
// - push increments the pointer register first, then writes the source to the new address.
// - opcode 83 is the three-byte, eight-cycle push with flags untouched.
// - opcode CF clears carry in four cycles and keeps the other flags.
// - return loads the program counter from the stack and then adds two to the pointer.
// - the byte at the current stack pointer becomes the program counter high byte.
// - opcode AF returns in eight cycles, or ten with the alternative stack, flags untouched.
// - rotate left moves bit 7 into bit 0 and the carry.
// - rotate left sets carry, zero and sign from the shifted bit and the result.
// - rotate left sets overflow and keeps decimal-adjust and half-carry.
// - overflow means the destination sign bit changed.
// - opcodes 90 and 91 rotate a direct or indirect register in four cycles.
`timescale 1ns/1ps
`include "usrre_consts.svh"
module usrre_exec
   import usrre_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [7:0] opcode,
   input wire logic [7:0] operandA,
   input wire logic [7:0] operandB,
   input wire logic extStack,
   input wire logic [7:0] regRdData,
   input wire logic [7:0] stkRdData,
   output logic [7:0] regAddr,
   output logic regWrEn,
   output logic [7:0] regWrData,
   output logic [15:0] stkAddr,
   output logic [15:0] pc,
   output logic [15:0] sp,
   output logic [7:0] flags,
   output logic busy,
   output logic done,
   output logic illegal
);
   typedef struct packed {
      usrre_state_type state;
      usrre_opkind_type kind;
      logic indirect;
      logic [3:0] cyclesLeft;
      logic [7:0] dstSel;
      logic [7:0] srcSel;
      logic [7:0] ptr;
      logic [7:0] regAddr;
      logic regWrEn;
      logic [7:0] regWrData;
      logic [15:0] stkAddr;
      logic [15:0] pc;
      logic [15:0] sp;
      logic [7:0] flags;
      logic busy;
      logic done;
      logic illegal;
   } usrre_regs_type;

   usrre_regs_type r_q, r_d;
   logic decLegal, decIndirect;
   usrre_opkind_type decKind;
   logic [3:0] decCycles;
   logic [7:0] rotResult, rotFlags;

   usrre_decode uDecode (
      .opcode(opcode),
      .extStack(extStack),
      .legal(decLegal),
      .kind(decKind),
      .indirect(decIndirect),
      .cycles(decCycles)
   );

   usrre_rotl uRotl (
      .operand(regRdData),
      .flagsIn(r_q.flags),
      .result(rotResult),
      .flagsOut(rotFlags)
   );

   function automatic logic [3:0] countDown(input logic [3:0] c);
      countDown = (c > 4'h1) ? c - 4'h1 : 4'h1;
   endfunction

   always_comb begin
      r_d = r_q;
      r_d.regWrEn = 1'b0;
      r_d.done = 1'b0;
      r_d.illegal = 1'b0;
      if (r_q.state != USRRE_IDLE) begin
         r_d.cyclesLeft = countDown(r_q.cyclesLeft);
      end
      unique case (r_q.state)
         USRRE_IDLE: begin
            r_d.busy = 1'b0;
            if (start) begin
               if (!decLegal) begin
                  r_d.illegal = 1'b1;
               end else begin
                  r_d.kind = decKind;
                  r_d.indirect = decIndirect;
                  r_d.dstSel = operandA;
                  r_d.srcSel = operandB;
                  r_d.cyclesLeft = decCycles;
                  r_d.busy = 1'b1;
                  r_d.regAddr = operandA;
                  r_d.stkAddr = r_q.sp;
                  unique case (decKind)
                     USRRE_OPK_PUSH: r_d.state = USRRE_PTR;
                     USRRE_OPK_CARRY: begin
                        r_d.flags[`USRRE_FLAG_C] = 1'b0;
                        r_d.state = USRRE_WAIT;
                     end
                     USRRE_OPK_RET: r_d.state = USRRE_STK_HI;
                     USRRE_OPK_ROTL: r_d.state = decIndirect ? USRRE_IND : USRRE_DATA;
                  endcase
               end
            end
         end
         USRRE_PTR: begin
            // pointer bumped and written back before the data lands
            r_d.ptr = regRdData + 8'h01;
            r_d.regAddr = r_q.dstSel;
            r_d.regWrData = regRdData + 8'h01;
            r_d.regWrEn = 1'b1;
            r_d.state = USRRE_IND;
         end
         USRRE_IND: begin
            if (r_q.kind == USRRE_OPK_PUSH) begin
               r_d.regAddr = r_q.srcSel;
               r_d.state = USRRE_DATA;
            end else begin
               r_d.regAddr = regRdData;
               r_d.state = USRRE_DATA;
            end
         end
         USRRE_DATA: begin
            r_d.regWrEn = 1'b1;
            r_d.state = USRRE_WAIT;
            if (r_q.kind == USRRE_OPK_PUSH) begin
               r_d.regAddr = r_q.ptr;
               r_d.regWrData = regRdData;
            end else begin
               r_d.regWrData = rotResult;
               r_d.flags = rotFlags;
            end
         end
         USRRE_STK_HI: begin
            r_d.pc[15:8] = stkRdData;
            r_d.stkAddr = r_q.sp + 16'h0001;
            r_d.state = USRRE_STK_LO;
         end
         USRRE_STK_LO: begin
            r_d.pc[7:0] = stkRdData;
            r_d.sp = r_q.sp + `USRRE_SP_STEP;
            r_d.state = USRRE_WAIT;
         end
         USRRE_WAIT: begin
            if (r_q.cyclesLeft <= 4'h2) begin
               r_d.state = USRRE_IDLE;
               r_d.busy = 1'b0;
               r_d.done = 1'b1;
            end
         end
         default: r_d.state = USRRE_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r_q <= '0;
         r_q.state <= USRRE_IDLE;
         r_q.kind <= USRRE_OPK_CARRY;
         r_q.pc <= `USRRE_PC_RESET;
         r_q.sp <= `USRRE_SP_RESET;
         r_q.flags <= `USRRE_FLAGS_RESET;
      end else begin
         r_q <= r_d;
      end
   end

   assign regAddr = r_q.regAddr;
   assign regWrEn = r_q.regWrEn;
   assign regWrData = r_q.regWrData;
   assign stkAddr = r_q.stkAddr;
   assign pc = r_q.pc;
   assign sp = r_q.sp;
   assign flags = r_q.flags;
   assign busy = r_q.busy;
   assign done = r_q.done;
   assign illegal = r_q.illegal;

   // helper: cycles from accepted start to done
   logic [3:0] elapsed;
   logic [3:0] expected;
   always_ff @(posedge clk) begin
      if (rst) begin
         elapsed <= 4'h0;
         expected <= 4'h0;
      end else if (start && !busy && decLegal) begin
         elapsed <= 4'h1;
         expected <= decCycles;
      end else if (busy) begin
         elapsed <= elapsed + 4'h1;
      end
   end

   AST_CYCLE_COUNT: assert property (@(posedge clk) disable iff (rst)
      $rose(done) |-> elapsed == expected)
      else $error("instruction length wrong");
   AST_CARRY_CLEAR: assert property (@(posedge clk) disable iff (rst)
      (start && !busy && opcode == `USRRE_OP_CARRY_CLR) |=> !flags[`USRRE_FLAG_C]
      && flags[6:0] == $past(flags[6:0]))
      else $error("carry clear wrong");
   AST_RET_SP: assert property (@(posedge clk) disable iff (rst)
      (start && !busy && opcode == `USRRE_OP_RETURN) |=> ##2 sp == $past(sp, 3) + 16'h0002)
      else $error("return pointer step wrong");
   AST_RET_HI: assert property (@(posedge clk) disable iff (rst)
      (r_q.state == USRRE_STK_HI) |=> pc[15:8] == $past(stkRdData))
      else $error("return high byte wrong");
   AST_RET_LO_ADDR: assert property (@(posedge clk) disable iff (rst)
      (r_q.state == USRRE_STK_LO) |-> stkAddr == sp + 16'h0001)
      else $error("return low byte address wrong");
   AST_ROT_RESULT: assert property (@(posedge clk) disable iff (rst)
      (r_q.state == USRRE_DATA && r_q.kind == USRRE_OPK_ROTL) |=>
      regWrEn && regWrData == {$past(regRdData[6:0]), $past(regRdData[7])})
      else $error("rotate result wrong");
   AST_ROT_FLAGS: assert property (@(posedge clk) disable iff (rst)
      (r_q.state == USRRE_DATA && r_q.kind == USRRE_OPK_ROTL) |=>
      flags[`USRRE_FLAG_C] == regWrData[0] && flags[`USRRE_FLAG_S] == regWrData[7]
      && flags[`USRRE_FLAG_Z] == (regWrData == 8'h00))
      else $error("rotate flags wrong");
   AST_ROT_V: assert property (@(posedge clk) disable iff (rst)
      (r_q.state == USRRE_DATA && r_q.kind == USRRE_OPK_ROTL) |=>
      flags[`USRRE_FLAG_V] == (regWrData[7] ^ regWrData[0]) && flags[3:0] == $past(flags[3:0]))
      else $error("rotate overflow wrong");
   AST_PUSH_ORDER: assert property (@(posedge clk) disable iff (rst)
      (r_q.state == USRRE_PTR) |=> regWrEn ##2 regWrEn && regAddr == $past(regWrData, 2))
      else $error("push order wrong");
   AST_PUSH_FLAGS: assert property (@(posedge clk) disable iff (rst)
      (r_q.kind == USRRE_OPK_PUSH && busy) |-> flags == $past(flags))
      else $error("push changed flags");
   // pointer write-back must carry the old pointer plus one, to the named register
   AST_PUSH_PTR_INC: assert property (@(posedge clk) disable iff (rst)
      (r_q.state == USRRE_PTR) |=>
      regWrData == $past(regRdData) + 8'h01 && regAddr == $past(r_q.dstSel))
      else $error("push pointer step wrong");
   AST_RET_HI_ADDR: assert property (@(posedge clk) disable iff (rst)
      (r_q.state == USRRE_STK_HI) |-> stkAddr == sp)
      else $error("return high byte address wrong");
   AST_RET_FLAGS: assert property (@(posedge clk) disable iff (rst)
      (r_q.kind == USRRE_OPK_RET && busy) |-> flags == $past(flags))
      else $error("return changed flags");
   // indirect rotate must address the register named by the pointer contents
   AST_IND_ADDR: assert property (@(posedge clk) disable iff (rst)
      (r_q.state == USRRE_IND && r_q.kind == USRRE_OPK_ROTL) |=>
      regAddr == $past(regRdData))
      else $error("indirect address wrong");
   // an unknown opcode only pulses illegal, no write and no busy
   AST_ILLEGAL_QUIET: assert property (@(posedge clk) disable iff (rst)
      (start && !busy && !decLegal) |=> illegal && !busy && !regWrEn)
      else $error("illegal opcode not refused");

   COV_PUSH: cover property (@(posedge clk) r_q.kind == USRRE_OPK_PUSH && done);
   COV_RET_EXT: cover property (@(posedge clk) r_q.kind == USRRE_OPK_RET && done && extStack);
   COV_ROT_IND: cover property (@(posedge clk) r_q.kind == USRRE_OPK_ROTL && r_q.indirect && done);
   COV_ILLEGAL: cover property (@(posedge clk) illegal);
   COV_CARRY: cover property (@(posedge clk) r_q.kind == USRRE_OPK_CARRY && done);
endmodule // usrre_exec

// ==== verification/usrre_tb.sv ====
/*
 Self-checking bench for the stack, return and rotate executor.
 Assumes the package and the executor are compiled first; the bench models the
 register file and the stack memory with same-cycle reads.
*/
`timescale 1ns/1ps
`include "usrre_consts.svh"
module tb
   import usrre_pkg::*;
;
   logic clk, rst, start, extStack, regWrEn, busy, done, illegal;
   logic [7:0] opcode, operandA, operandB, regRdData, stkRdData, regAddr, regWrData, flags;
   logic [15:0] stkAddr, pc, sp;
   logic [7:0] rf [256];
   logic [7:0] stk [256];
   logic [7:0] efl;
   int n_mismatch, tests_run;

   usrre_exec dut (.clk(clk), .rst(rst), .start(start), .opcode(opcode),
      .operandA(operandA), .operandB(operandB), .extStack(extStack),
      .regRdData(regRdData), .stkRdData(stkRdData), .regAddr(regAddr),
      .regWrEn(regWrEn), .regWrData(regWrData), .stkAddr(stkAddr), .pc(pc),
      .sp(sp), .flags(flags), .busy(busy), .done(done), .illegal(illegal));

   always #20 clk = ~clk;
   assign regRdData = rf[regAddr];
   // stack is mirrored every 256 bytes, enough for the pointer range used here
   assign stkRdData = stk[stkAddr[7:0]];
   always @(posedge clk) begin
      if (regWrEn) begin
         rf[regAddr] <= regWrData;
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // called at a falling edge; poke tries a start while busy, which must be ignored
   task automatic run(input logic [7:0] op, a, b, input logic ext, poke, input int ncyc);
      int cyc;
      opcode = op;
      operandA = a;
      operandB = b;
      extStack = ext;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      cyc = 1;
      if (ncyc == 0) begin
         check({busy, illegal}, 16'h0001);
      end else begin
         while (done !== 1'b1 && cyc < 20) begin
            if (poke && cyc == 3) begin
               start = 1'b1;
               opcode = `USRRE_OP_CARRY_CLR;
            end
            @(negedge clk);
            start = 1'b0;
            cyc++;
         end
         check(16'(cyc), 16'(ncyc));
         check(16'(busy), 16'h0000);
      end
      $display("test opcode %h ended after %0d cycles", op, cyc);
   endtask

   task automatic do_push(input logic [7:0] a, b);
      logic [7:0] e [256];
      e = rf;
      e[a] = e[a] + 8'h01;
      e[e[a]] = e[b];
      run(`USRRE_OP_PUSH_INC, a, b, 1'b0, 1'b0, `USRRE_CYC_PUSH);
      check(rf[a], e[a]);
      check(rf[e[a]], e[e[a]]);
      check(flags, efl);
   endtask

   task automatic do_rot(input logic [7:0] a, input logic ind);
      logic [7:0] ad, v, r;
      ad = ind ? rf[a] : a;
      v = rf[ad];
      r = {v[6:0], v[7]};
      efl[`USRRE_FLAG_C] = v[7];
      efl[`USRRE_FLAG_Z] = (r == 8'h00);
      efl[`USRRE_FLAG_S] = r[7];
      efl[`USRRE_FLAG_V] = v[7] ^ r[7];
      run(ind ? `USRRE_OP_ROTL_IR : `USRRE_OP_ROTL_R, a, 8'h00, 1'b0, 1'b0, `USRRE_CYC_ROTL);
      check(rf[ad], r);
      check(flags, efl);
   endtask

   task automatic do_ret(input logic ext, poke);
      logic [15:0] epc, esp;
      epc = {stk[sp[7:0]], stk[sp[7:0] + 8'h01]};
      esp = sp + 16'h0002;
      run(`USRRE_OP_RETURN, 8'h00, 8'h00, ext, poke,
         ext ? `USRRE_CYC_RET_EXT : `USRRE_CYC_RET_INT);
      check(pc, epc);
      check(sp, esp);
      check(stkAddr, esp - 16'h0001);
      check(flags, efl);
   endtask

   task automatic do_clr;
      efl[`USRRE_FLAG_C] = 1'b0;
      run(`USRRE_OP_CARRY_CLR, 8'h00, 8'h00, 1'b0, 1'b0, `USRRE_CYC_CARRY);
      check(flags, efl);
   endtask

   initial begin
      logic [7:0] a, b;
      clk = 1'b0;
      rst = 1'b1;
      start = 1'b0;
      opcode = 8'h00;
      operandA = 8'h00;
      operandB = 8'h00;
      extStack = 1'b0;
      n_mismatch = 0;
      tests_run = 0;
      efl = `USRRE_FLAGS_RESET;
      void'($urandom(80127));
      for (int i = 0; i < 256; i++) begin
         rf[i] = 8'($urandom);
         stk[i] = 8'($urandom);
      end
      rf[8'h10] = 8'hAA;
      rf[8'h11] = 8'h12;
      rf[8'h12] = 8'h17;
      rf[8'h13] = 8'h00;
      rf[8'h20] = 8'hFF;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      check(pc, `USRRE_PC_RESET);
      check(sp, `USRRE_SP_RESET);
      check(16'({flags, busy, done, illegal, regWrEn}), 16'h0000);
      do_rot(8'h10, 1'b0);
      do_clr;
      do_rot(8'h11, 1'b1);
      do_rot(8'h13, 1'b0);
      // pointer at FF wraps to 00
      do_push(8'h20, 8'h21);
      do_ret(1'b0, 1'b0);
      do_ret(1'b1, 1'b1);
      run(8'h82, 8'h00, 8'h00, 1'b0, 1'b0, 0);
      check(flags, efl);
      for (int i = 0; i < 60; i++) begin
         a = 8'($urandom);
         b = 8'($urandom);
         if (b == a) begin
            b = a + 8'h01;
         end
         case ($urandom_range(4))
            0: do_push(a, b);
            1: do_rot(a, 1'b0);
            2: do_rot(a, 1'b1);
            3: do_ret(1'($urandom), 1'($urandom));
            default: do_clr;
         endcase
      end
      complete_run;
   end

   // about four hundred cycles expected; five thousand is ample
   initial begin
      #200000;
      n_mismatch++;
      complete_run;
   end
endmodule // tb
